// ---- design/irq_ctrl.sv ----
`timescale 1ns/1ps
module irq_ctrl
  import irq_ctrl_pkg::*;
#(
  parameter int PC_W = 13
) (
  input wire logic sys_clk_i, // instruction clock
  input wire logic rst_b_i, // sync reset, active low
  input wire logic ce_i, // freezes all state when low
  input wire logic ext_irq_pin_i, // external interrupt pin
  input wire logic [7:0] option_reg_i, // option register, bit 6 edge select
  input wire logic timer0_wrap_i, // pulse: timer0 count wrapped to zero
  input wire logic port_change_i, // pulse: change on enabled port pins
  input wire periph_evt_s periph_evt_i, // pulses from peripherals
  input wire reg_wr_s reg_wr_i, // core register write
  input wire logic return_from_irq_instr_i, // pulse: return instruction executed
  input wire logic sleep_i, // core is asleep
  input wire logic instr_done_i, // pulse: core retired an instruction
  output irq_regs_s regs_o, // register contents
  output logic irq_req_o, // level: request to core
  output logic irq_take_o, // pulse: push return, load vector
  output logic [PC_W-1:0] vector_addr_o, // vector address
  output logic wake_o // pulse: wake the core
);
  // ==========================================================
  // elaboration check
  if (PC_W < 3 || PC_W > 16) begin : g_bad_pc
    $error("irq_ctrl: PC_W must lie in 3..16");
  end

  logic [7:0] ctl_ff;
  logic [7:0] pfa_ff;
  logic [7:0] pea_ff;
  logic [7:0] pfb_ff;
  logic [7:0] peb_ff;
  logic [7:0] nxt_ctl;
  logic [7:0] nxt_pfa;
  logic [7:0] nxt_pea;
  logic [7:0] nxt_pfb;
  logic [7:0] nxt_peb;
  logic req_ff;
  logic take_ff;
  logic wake_ff;
  logic [PC_W-1:0] vec_ff;
  wake_st_e st_ff;
  wake_st_e nxt_st;
  logic ext_edge;
  logic wr_ctl;
  logic wr_pfa;
  logic wr_pea;
  logic wr_pfb;
  logic wr_peb;
  logic gie_clr_wr;
  logic core_pend;
  logic per_pend;
  logic pending;
  logic can_take;

  // ==========================================================
  // external pin
  pin_edge_sync u_pin_edge (
    .sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .pin_i(ext_irq_pin_i),
    .rise_sel_i(option_reg_i[OPT_EDGE]),
    .edge_o(ext_edge)
  );

  // ==========================================================
  // write decode
  assign wr_ctl = reg_wr_i.en && reg_wr_i.sel == SEL_CTL;
  assign wr_pfa = reg_wr_i.en && reg_wr_i.sel == SEL_PFA;
  assign wr_pea = reg_wr_i.en && reg_wr_i.sel == SEL_PEA;
  assign wr_pfb = reg_wr_i.en && reg_wr_i.sel == SEL_PFB;
  assign wr_peb = reg_wr_i.en && reg_wr_i.sel == SEL_PEB;
  assign gie_clr_wr = wr_ctl && !reg_wr_i.data[CTL_GIE];

  // ==========================================================
  // pending and take
  // each core flag sits three bits below its enable
  assign core_pend = |(ctl_ff[CTL_T0F:CTL_PCF] & ctl_ff[CTL_T0E:CTL_PCE]);
  assign per_pend = ctl_ff[CTL_PGE] && |((pfa_ff & pea_ff) | (pfb_ff & peb_ff));
  assign pending = core_pend || per_pend;
  // a write clearing the enable masks the take in the same cycle, flags untouched
  assign can_take = ce_i && ctl_ff[CTL_GIE] && pending && !gie_clr_wr
                    && st_ff == ST_RUN && !sleep_i;

  // ==========================================================
  // control register; hardware sets win over a software clear
  always_comb begin
    nxt_ctl = wr_ctl ? reg_wr_i.data : ctl_ff;
    nxt_ctl[CTL_T0F] = nxt_ctl[CTL_T0F] | timer0_wrap_i;
    nxt_ctl[CTL_EXF] = nxt_ctl[CTL_EXF] | ext_edge;
    nxt_ctl[CTL_PCF] = nxt_ctl[CTL_PCF] | port_change_i;
    if (can_take) begin
      nxt_ctl[CTL_GIE] = 1'b0;
    end else if (return_from_irq_instr_i) begin
      nxt_ctl[CTL_GIE] = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      ctl_ff <= CTL_RST;
    end else if (ce_i) begin
      ctl_ff <= nxt_ctl;
    end
  end

  // ==========================================================
  // peripheral flag and enable registers
  for (genvar g = 0; g < 8; g++) begin : g_per
    always_comb begin
      nxt_pfa[g] = PFA_IMPL[g] & ((wr_pfa ? reg_wr_i.data[g] : pfa_ff[g])
                                  | periph_evt_i.a[g]);
      nxt_pfb[g] = PFB_IMPL[g] & ((wr_pfb ? reg_wr_i.data[g] : pfb_ff[g])
                                  | periph_evt_i.b[g]);
      nxt_pea[g] = PFA_IMPL[g] & (wr_pea ? reg_wr_i.data[g] : pea_ff[g]);
      nxt_peb[g] = PFB_IMPL[g] & (wr_peb ? reg_wr_i.data[g] : peb_ff[g]);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      pfa_ff <= PER_RST;
      pea_ff <= PER_RST;
      pfb_ff <= PER_RST;
      peb_ff <= PER_RST;
    end else if (ce_i) begin
      pfa_ff <= nxt_pfa;
      pea_ff <= nxt_pea;
      pfb_ff <= nxt_pfb;
      peb_ff <= nxt_peb;
    end
  end

  // ==========================================================
  // request, take and vector
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      req_ff <= 1'b0;
      take_ff <= 1'b0;
      vec_ff <= '0;
    end else if (ce_i) begin
      req_ff <= ctl_ff[CTL_GIE] && pending;
      take_ff <= can_take;
      if (can_take) begin
        vec_ff <= IRQ_VECTOR[PC_W-1:0];
      end
    end
  end

  // ==========================================================
  // sleep wake-up; enabled sources wake whatever the global enable
  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      ST_RUN: begin
        if (sleep_i && pending) begin
          nxt_st = ST_WAKE_STEP;
        end
      end
      ST_WAKE_STEP: begin
        // the instruction after the sleep retires before any vectoring
        if (!sleep_i && instr_done_i) begin
          nxt_st = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      st_ff <= ST_RUN;
      wake_ff <= 1'b0;
    end else if (ce_i) begin
      st_ff <= nxt_st;
      wake_ff <= st_ff == ST_RUN && nxt_st == ST_WAKE_STEP;
    end
  end

  assign regs_o = '{ctl: ctl_ff, pfa: pfa_ff, pea: pea_ff, pfb: pfb_ff, peb: peb_ff};
  assign irq_req_o = req_ff;
  assign irq_take_o = take_ff;
  assign vector_addr_o = vec_ff;
  assign wake_o = wake_ff;

  // ==========================================================
  // assertions
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  // a valid edge for the current select, new level held three cycles, select steady
  sequence s_edge_held;
    ce_i && ext_irq_pin_i != option_reg_i[OPT_EDGE]
    ##1 (ce_i && ext_irq_pin_i == option_reg_i[OPT_EDGE]
         && $stable(option_reg_i[OPT_EDGE])) [*3];
  endsequence

  // the write only drops the enable; flags and other enables are kept
  sequence s_gie_clear_on_pending;
    ce_i && ctl_ff[CTL_GIE] && pending && gie_clr_wr
    && reg_wr_i.data[CTL_GIE-1:0] == ctl_ff[CTL_GIE-1:0];
  endsequence

  a_reset_clears_gie: assert property (disable iff (1'b0)
    !rst_b_i |=> !ctl_ff[CTL_GIE]) else $error("global enable survived reset");

  a_take_clears_gie: assert property (
    irq_take_o |-> !ctl_ff[CTL_GIE] && vector_addr_o == IRQ_VECTOR[PC_W-1:0])
    else $error("take did not clear enable or load vector");

  a_take_needs_gie: assert property (
    irq_take_o |-> $past(ctl_ff[CTL_GIE]) && $past(pending))
    else $error("take without global enable and pending flag");

  a_return_from_irq_instr_sets_gie: assert property (
    ce_i && return_from_irq_instr_i && !can_take |=> ctl_ff[CTL_GIE])
    else $error("return instruction did not set global enable");

  a_ext_edge_flag: assert property (
    s_edge_held |=> ctl_ff[CTL_EXF]) else $error("pin edge missed its flag");

  a_ext_latency: assert property (
    s_edge_held ##0 ctl_ff[CTL_GIE] && ctl_ff[CTL_EXE] && st_ff == ST_RUN && !sleep_i
    && !gie_clr_wr && !return_from_irq_instr_i && !wr_ctl
    |=> ##[0:1] irq_take_o) else $error("pin interrupt latency exceeded");

  a_gie_clear_pending: assert property (
    s_gie_clear_on_pending |=> !irq_take_o && pending)
    else $error("take not cancelled or request lost on enable clear");

  a_timer_flag_set: assert property (
    ce_i && timer0_wrap_i |=> ctl_ff[CTL_T0F]) else $error("timer0 wrap flag not set");

  a_req_follows: assert property (
    ce_i && !ctl_ff[CTL_GIE] |=> !irq_req_o) else $error("request with enable clear");

  a_wake_step: assert property (
    st_ff == ST_WAKE_STEP |-> !can_take ##1 !irq_take_o)
    else $error("vectored before the post-wake instruction");

  a_unimpl_zero: assert property (
    !pfa_ff[7] && !pea_ff[7] && !pfb_ff[1] && !peb_ff[1])
    else $error("unimplemented peripheral bit set");
endmodule

// ---- common/irq_ctrl_pkg.sv ----
package irq_ctrl_pkg;
  // ==========================================================
  // control register fields
  localparam int CTL_PCF = 0;
  localparam int CTL_EXF = 1;
  localparam int CTL_T0F = 2;
  localparam int CTL_PCE = 3;
  localparam int CTL_EXE = 4;
  localparam int CTL_T0E = 5;
  localparam int CTL_PGE = 6;
  localparam int CTL_GIE = 7;
  localparam int ENA_OFS = 3;
  localparam int OPT_EDGE = 6;
  // ==========================================================
  // reset values and implemented bits
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] PER_RST = 8'h00;
  localparam logic [7:0] PFA_IMPL = 8'h7f;
  localparam logic [7:0] PFB_IMPL = 8'hfd;
  localparam logic [15:0] IRQ_VECTOR = 16'h0004;
  localparam int SYNC_STAGES = 2;
  // ==========================================================
  // carriers
  typedef enum logic [2:0] {SEL_CTL, SEL_PFA, SEL_PEA, SEL_PFB, SEL_PEB} reg_sel_e;
  typedef struct packed {
    logic en;
    reg_sel_e sel;
    logic [7:0] data;
  } reg_wr_s;
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] pfa;
    logic [7:0] pea;
    logic [7:0] pfb;
    logic [7:0] peb;
  } irq_regs_s;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
  } periph_evt_s;
  typedef enum logic {ST_RUN, ST_WAKE_STEP} wake_st_e;
endpackage

// ---- design/pin_edge_sync.sv ----
`timescale 1ns/1ps
module pin_edge_sync
  import irq_ctrl_pkg::*;
(
  input wire logic sys_clk_i, // instruction clock
  input wire logic rst_b_i, // sync reset, active low
  input wire logic ce_i, // clock enable
  input wire logic pin_i, // asynchronous pin
  input wire logic rise_sel_i, // 1 rising, 0 falling
  output logic edge_o // one-cycle valid edge
);
  logic [SYNC_STAGES-1:0] sync_ff;
  logic prev_ff;

  // ==========================================================
  // synchroniser; only the last stage feeds the edge compare
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      sync_ff <= '0;
      prev_ff <= 1'b0;
    end else if (ce_i) begin
      sync_ff <= {sync_ff[SYNC_STAGES-2:0], pin_i};
      prev_ff <= sync_ff[SYNC_STAGES-1];
    end
  end

  // flipping the edge select raises no edge with the pin steady; the compare needs the last stage and prev_ff to differ
  assign edge_o = ce_i && (rise_sel_i ? (sync_ff[SYNC_STAGES-1] && !prev_ff)
                                      : (!sync_ff[SYNC_STAGES-1] && prev_ff));
endmodule

// ---- testbench/core_model.sv ----
`timescale 1ns/1ps
module core_model
  import irq_ctrl_pkg::*;
#(
  parameter int PC_W = 13
) (
  input wire logic sys_clk_i, // instruction clock
  input wire logic rst_b_i, // sync reset, active low
  input wire logic sleep_req_i, // pulse: software enters sleep
  input wire logic wake_i, // wake pulse from the controller
  input wire logic take_i, // vector pulse from the controller
  input wire logic [PC_W-1:0] vector_i, // vector address
  output logic sleep_o, // core asleep
  output logic instr_done_o, // pulse: instruction retired
  output logic [7:0] take_cnt_o, // vectors taken
  output logic [7:0] step_cnt_o // instructions run after a wake
);
  // ==========================================================
  // fetch and stack
  logic [PC_W-1:0] pc_ff;
  logic [PC_W-1:0] stack_ff;
  logic step_ff;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      {pc_ff, stack_ff, step_ff, sleep_o, instr_done_o, take_cnt_o, step_cnt_o} <= '0;
    end else begin
      instr_done_o <= 1'b0;
      if (take_i) begin
        stack_ff <= pc_ff;
        pc_ff <= vector_i;
        take_cnt_o <= take_cnt_o + 8'h01;
      end
      if (sleep_req_i) begin
        sleep_o <= 1'b1;
      end
      // the core leaves sleep a cycle late, then runs one instruction
      if (wake_i) begin
        sleep_o <= 1'b0;
        step_ff <= 1'b1;
      end
      if (step_ff) begin
        step_ff <= 1'b0;
        instr_done_o <= 1'b1;
        step_cnt_o <= step_cnt_o + 8'h01;
        pc_ff <= pc_ff + 1'b1;
      end
    end
  end
endmodule

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import irq_ctrl_pkg::*;
  logic sys_clk_i = 0, rst_b_i = 0, pin = 0, t0w = 0, pcw = 0, rfi = 0, slp_rq = 0;
  logic [7:0] opt = 8'h40;
  periph_evt_s pev = '0;
  reg_wr_s wr = '0;
  irq_regs_s regs;
  logic req, take, wake, slp, done;
  logic [12:0] vec;
  logic [7:0] tk, st;
  int err_total = 0, compares = 0, ticks = 0, n;
  always #20 sys_clk_i = ~sys_clk_i;
  irq_ctrl irq_ctrl_i(.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .ce_i(1'b1),
    .ext_irq_pin_i(pin), .option_reg_i(opt), .timer0_wrap_i(t0w), .port_change_i(pcw),
    .periph_evt_i(pev), .reg_wr_i(wr), .return_from_irq_instr_i(rfi), .sleep_i(slp),
    .instr_done_i(done), .regs_o(regs), .irq_req_o(req), .irq_take_o(take),
    .vector_addr_o(vec), .wake_o(wake));
  core_model core_model_i(.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .sleep_req_i(slp_rq),
    .wake_i(wake), .take_i(take), .vector_i(vec), .sleep_o(slp), .instr_done_o(done),
    .take_cnt_o(tk), .step_cnt_o(st));
  // ==========================================================
  // access tasks
  task test_done;
    if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [47:0] got, input logic [47:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask
  task wreg(input reg_sel_e s, input logic [7:0] d);
    @(posedge sys_clk_i);
    wr <= '{1'b1, s, d};
    @(posedge sys_clk_i);
    wr <= '0;
    #1;
  endtask
  task pulse(input int k);
    @(posedge sys_clk_i);
    case (k)
      0: t0w <= 1'b1;
      1: pcw <= 1'b1;
      2: rfi <= 1'b1;
      default: slp_rq <= 1'b1;
    endcase
    @(posedge sys_clk_i);
    {t0w, pcw, rfi, slp_rq} <= '0;
    #1;
  endtask
  task pin_to(input logic v);
    @(posedge sys_clk_i);
    pin <= v;
    #1;
  endtask
  // k 0 waits for a vector pulse, 1 for a wake pulse
  task wait_sig(input int k, output int c);
    c = 0;
    while (((k == 0) ? take : wake) !== 1'b1 && c < 12) begin
      cyc(1);
      c++;
    end
  endtask
  always @(posedge sys_clk_i) begin
    ticks++;
    if (ticks > 3000) begin
      err_total++;
      test_done;
    end
  end
  // ==========================================================
  // scenarios
  initial begin
    repeat (10) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    #1;
    chk({regs, req, take}, '0);
    pulse(0);
    pulse(1);
    @(posedge sys_clk_i);
    pev <= '{8'hff, 8'hff};
    @(posedge sys_clk_i);
    pev <= '0;
    #1;
    chk(regs, {8'h05, 8'h7f, 8'h00, 8'hfd, 8'h00});
    wreg(SEL_CTL, 8'h2d);
    cyc(3);
    chk({req, take, tk}, '0);
    wreg(SEL_CTL, 8'had);
    wait_sig(0, n);
    cyc(1);
    chk({tk, 3'h0, vec, regs.ctl}, {8'h01, IRQ_VECTOR, 8'h2d});
    pulse(2); // flags left set on purpose
    wait_sig(0, n);
    chk(take, 1'b1);
    wreg(SEL_CTL, 8'h28);
    pulse(2);
    cyc(3);
    chk({regs.ctl, tk}, {8'ha8, 8'h02});
    wreg(SEL_PEA, 8'h01);
    cyc(3);
    chk(tk, 8'h02);
    wreg(SEL_CTL, 8'he8);
    wait_sig(0, n);
    chk(take, 1'b1);
    wreg(SEL_PFA, 8'h00);
    wreg(SEL_PEB, 8'hff);
    wreg(SEL_CTL, 8'he8);
    wait_sig(0, n);
    chk({take, regs.peb}, {1'b1, 8'hfd});
    wreg(SEL_PFB, 8'h00);
    wreg(SEL_CTL, 8'h00);
    pulse(1);
    @(posedge sys_clk_i);
    wr <= '{1'b1, SEL_CTL, 8'h89};
    @(posedge sys_clk_i);
    wr <= '{1'b1, SEL_CTL, 8'h09};
    @(posedge sys_clk_i);
    wr <= '0;
    cyc(3);
    chk({regs.ctl, tk}, {8'h09, 8'h04});
    wreg(SEL_CTL, 8'h89);
    wait_sig(0, n);
    chk({take, req}, 2'b11);
    wreg(SEL_CTL, 8'h80);
    pin_to(1);
    cyc(5);
    chk({regs.ctl, tk}, {8'h82, 8'h05});
    wreg(SEL_CTL, 8'h90);
    pin_to(0);
    cyc(5);
    @(posedge sys_clk_i);
    opt <= 8'h00;
    pin_to(1);
    cyc(5);
    chk(regs.ctl, 8'h90);
    pin_to(0);
    wait_sig(0, n);
    chk(n - 1 >= 3 && n - 1 <= 4, 1'b1);
    wreg(SEL_CTL, 8'h10);
    @(posedge sys_clk_i);
    opt <= 8'h40;
    pulse(3);
    pin_to(1);
    wait_sig(1, n);
    chk(wake, 1'b1);
    cyc(6);
    chk({tk, st, regs.ctl}, {8'h06, 8'h01, 8'h12});
    wreg(SEL_CTL, 8'h90);
    pin_to(0);
    pulse(3);
    pin_to(1);
    wait_sig(1, n);
    wait_sig(0, n);
    chk({take, st, vec}, {1'b1, 8'h02, IRQ_VECTOR[12:0]});
    test_done;
  end
endmodule
